// File: design/aqr_cfg.svh
// Overview of operation
// R1: bit 7 lets queue fill in low power
// R2: bits 5..3 put X/Y/Z axes in standby
// R3: fill count is 13 bits, high/low bytes
// R4: high byte read latches both count bytes
// R5: host reads high byte before low byte
// R6: data port read pops, write pushes
// R7: enabled sensor bytes appended in register order
// R8: byte stored only when its source enabled
// R9: overflow raises queue overflow status flag
// R10: overflow drops oldest unless keep mode set
// R11: empty data port read returns 0xFF
// R12: sensor data never stored as 0xFF
// R13: identity register returns fixed read-only code
// R14: bus address 0x68 or 0x69 by pin
// R15: 15-bit offsets split high byte, low [7:1]
// R16: offset steps fixed, independent of range
// R17: host preserves factory bit 0 of low bytes
// R18: queue reset bit clears the queue
// R19: access enable gates serial queue access
// R20: cycling with all axes standby takes no samples
// R21: fill count tracks pushes and pops
// R22: reserved bits read zero, ignore writes
`ifndef AQR_CFG_SVH
`define AQR_CFG_SVH
// ****************************************
// register offsets
// ****************************************
`define AQR_OFS_PWR2      7'h6C
`define AQR_OFS_LVL_HI    7'h72
`define AQR_OFS_LVL_LO    7'h73
`define AQR_OFS_DATA      7'h74
`define AQR_OFS_IDENT     7'h75
`define AQR_OFS_XOFS_HI   7'h77
`define AQR_OFS_XOFS_LO   7'h78
`define AQR_OFS_YOFS_HI   7'h7A
`define AQR_OFS_YOFS_LO   7'h7B
`define AQR_OFS_ZOFS_HI   7'h7D
`define AQR_OFS_ZOFS_LO   7'h7E
// ****************************************
// fields, reset values, constants
// ****************************************
`define AQR_BIT_LP_ALLOW  3'd7
`define AQR_BIT_X_STBY    3'd5
`define AQR_BIT_Y_STBY    3'd4
`define AQR_BIT_Z_STBY    3'd3
`define AQR_PWR2_MASK     8'hB8
`define AQR_RST_PWR2      8'h00
`define AQR_RST_OFS       8'h00
`define AQR_EMPTY_CODE    8'hFF
`define AQR_CLAMP_CODE    8'hFE
`define AQR_I2C_ADDR_BASE 7'h68
`define AQR_SRC_BYTES     14
`define AQR_LAST_IDX      4'hD
`define AQR_Q_DEPTH       32
`endif

// File: design/aqr_pkg.sv
package aqr_pkg;
    typedef logic [7:0]  aqr_byte_t;
    typedef logic [12:0] aqr_level_t;
    typedef logic [14:0] aqr_offset_t;
    typedef enum logic [0:0] {
        AQR_IDLE = 1'b0,
        AQR_WALK = 1'b1
    } aqr_state_t;
endpackage

// File: design/aqr_regs.sv
`timescale 1ns/1ps
`include "aqr_cfg.svh"

// ****************************************
// byte queue, show-ahead, sync clear
// ****************************************
module aqr_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   clr,
    input  wire logic                   in_valid,
    output logic                        in_ready,
    input  wire logic [W-1:0]           in_data,
    output logic                        out_valid,
    input  wire logic                   out_ready,
    output logic [W-1:0]                out_data,
    output logic [$clog2(D):0]          count
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    // full queue still takes a byte when one leaves
    assign out_valid = (cnt_q != '0);
    assign in_ready  = (cnt_q != D[AW:0]) || out_ready;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rp_q];
    assign count     = cnt_q;

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk) begin
        if (rst || clr) begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) wp_q <= wp_q + 1'b1;
            if (pop) rp_q <= rp_q + 1'b1;
            cnt_q <= cnt_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end
endmodule

// ****************************************
// upper register bank with queue
// ****************************************
module aqr_regs #(
    parameter logic [7:0] ID_CODE = 8'h5A  // arbitrary value
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [6:0]             reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire aqr_pkg::aqr_byte_t     reg_wdata,
    output aqr_pkg::aqr_byte_t          reg_rdata,
    output logic                        reg_rvalid,
    input  wire logic                   address_select_pin,
    output logic [6:0]                  i2c_address,
    input  wire logic                   sample_tick,
    input  wire logic [111:0]           sensor_bytes,
    input  wire logic [13:0]            source_enable,
    input  wire logic                   queue_keep_mode,
    input  wire logic                   queue_access_en,
    input  wire logic                   queue_reset,
    input  wire logic                   low_power_cycling,
    output logic                        queue_low_power_allow,
    output logic                        x_axis_standby,
    output logic                        y_axis_standby,
    output logic                        z_axis_standby,
    output logic                        queue_overflow_flag,
    output aqr_pkg::aqr_offset_t        x_offset_value,
    output aqr_pkg::aqr_offset_t        y_offset_value,
    output aqr_pkg::aqr_offset_t        z_offset_value,
    output logic                        factory_x_bit,
    output logic                        factory_y_bit,
    output logic                        factory_z_bit
);
    import aqr_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ****************************************
    // state
    // ****************************************
    aqr_byte_t   pwr2_q;
    aqr_byte_t   ofs_q [6];
    aqr_byte_t   snap_q [`AQR_SRC_BYTES];
    aqr_level_t  lat_q;
    aqr_byte_t   rdata_q;
    logic        rvalid_q;
    logic        ovf_q;
    logic [1:0]  sel_sync_q;
    logic [6:0]  addr_q;
    aqr_state_t  st_q;
    aqr_state_t  st_d;
    logic [3:0]  idx_q;
    logic [3:0]  idx_d;

    // ****************************************
    // decode
    // ****************************************
    function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
        hit = (a == ofs);
    endfunction

    logic        wr_pwr2;
    logic        rd_hi;
    logic        rd_lo;
    logic        rd_data;
    logic        wr_data;
    logic        host_pop;
    logic        host_push;
    logic [5:0]  wr_ofs;
    aqr_level_t  level;
    logic [5:0]  q_cnt;
    logic        q_in_ready;
    logic        q_out_valid;
    aqr_byte_t   q_out_data;
    logic        q_in_valid;
    aqr_byte_t   q_in_data;
    logic        q_full;
    logic        drop_old;
    logic        all_stby;
    logic        may_sample;
    logic        start;
    aqr_byte_t   cur_byte;
    aqr_byte_t   clamp_byte;
    logic        cur_en;
    logic        want;
    logic        step;
    logic        ovf_evt;
    aqr_byte_t   rd_mux;

    assign wr_pwr2   = reg_wr && hit(reg_addr, `AQR_OFS_PWR2);
    assign rd_hi     = reg_rd && hit(reg_addr, `AQR_OFS_LVL_HI);
    assign rd_lo     = reg_rd && hit(reg_addr, `AQR_OFS_LVL_LO);
    assign rd_data   = reg_rd && hit(reg_addr, `AQR_OFS_DATA);
    assign wr_data   = reg_wr && hit(reg_addr, `AQR_OFS_DATA);
    assign host_pop  = rd_data && queue_access_en && q_out_valid;  // R6 R19
    assign host_push = wr_data && queue_access_en;  // R6 R19
    assign wr_ofs[0] = reg_wr && hit(reg_addr, `AQR_OFS_XOFS_HI);
    assign wr_ofs[1] = reg_wr && hit(reg_addr, `AQR_OFS_XOFS_LO);
    assign wr_ofs[2] = reg_wr && hit(reg_addr, `AQR_OFS_YOFS_HI);
    assign wr_ofs[3] = reg_wr && hit(reg_addr, `AQR_OFS_YOFS_LO);
    assign wr_ofs[4] = reg_wr && hit(reg_addr, `AQR_OFS_ZOFS_HI);
    assign wr_ofs[5] = reg_wr && hit(reg_addr, `AQR_OFS_ZOFS_LO);
    assign level     = {7'h00, q_cnt};  // R3 R21

    // ****************************************
    // sampling walker
    // ****************************************
    assign all_stby   = pwr2_q[`AQR_BIT_X_STBY] && pwr2_q[`AQR_BIT_Y_STBY] && pwr2_q[`AQR_BIT_Z_STBY];
    // low power cycling needs the allow bit and a live axis
    assign may_sample = queue_access_en &&
                        (!low_power_cycling || (pwr2_q[`AQR_BIT_LP_ALLOW] && !all_stby));  // R1 R20
    assign start      = sample_tick && may_sample && (st_q == AQR_IDLE);
    assign cur_byte   = snap_q[idx_q];
    assign clamp_byte = (cur_byte == `AQR_EMPTY_CODE) ? `AQR_CLAMP_CODE : cur_byte;  // R12
    assign cur_en     = source_enable[idx_q];  // R8
    assign want       = (st_q == AQR_WALK) && cur_en && !host_push;
    assign q_full     = (q_cnt == 6'(`AQR_Q_DEPTH));
    assign drop_old   = want && q_full && !queue_keep_mode && !host_pop;  // R10
    assign ovf_evt    = want && q_full && !host_pop;  // R9
    // host write has the port first, walker waits a cycle
    assign step       = (st_q == AQR_WALK) && (!cur_en || (!host_push && (q_in_ready || queue_keep_mode)));
    assign q_in_valid = host_push || (want && !(q_full && queue_keep_mode && !host_pop));
    assign q_in_data  = host_push ? reg_wdata : clamp_byte;

    // next state of the walker
    always_comb begin
        st_d  = st_q;
        idx_d = idx_q;
        case (st_q)
            AQR_IDLE: begin
                if (start) begin
                    st_d  = AQR_WALK;
                    idx_d = 4'h0;
                end
            end
            AQR_WALK: begin
                if (step) begin
                    idx_d = (idx_q == `AQR_LAST_IDX) ? 4'h0 : idx_q + 4'h1;  // R7
                    if (idx_q == `AQR_LAST_IDX) begin
                        st_d = AQR_IDLE;
                    end
                end
            end
            default: begin
                st_d  = AQR_IDLE;
                idx_d = 4'h0;
            end
        endcase
    end

    // walker registers, queue reset aborts a walk
    always_ff @(posedge clk) begin
        if (rst || queue_reset) begin
            st_q  <= AQR_IDLE;
            idx_q <= 4'h0;
        end else begin
            st_q  <= st_d;
            idx_q <= idx_d;
        end
    end

    // sensor byte snapshot at the tick
    for (genvar g = 0; g < `AQR_SRC_BYTES; g++) begin : g_snap
        always_ff @(posedge clk) begin
            if (start) begin
                snap_q[g] <= sensor_bytes[g*8 +: 8];
            end
        end
    end

    aqr_fifo #(
        .W (8),
        .D (`AQR_Q_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .clr       (queue_reset),  // R18
        .in_valid  (q_in_valid),
        .in_ready  (q_in_ready),
        .in_data   (q_in_data),
        .out_valid (q_out_valid),
        .out_ready (host_pop || drop_old),
        .out_data  (q_out_data),
        .count     (q_cnt)
    );

    // ****************************************
    // registers
    // ****************************************
    // power control two, reserved bits held at zero
    always_ff @(posedge clk) begin
        if (rst) begin
            pwr2_q <= `AQR_RST_PWR2;
        end else if (wr_pwr2) begin
            pwr2_q <= reg_wdata & `AQR_PWR2_MASK;  // R1 R2 R22
        end
    end

    // offset bytes, all bits writable
    for (genvar g = 0; g < 6; g++) begin : g_ofs
        always_ff @(posedge clk) begin
            if (rst) begin
                ofs_q[g] <= `AQR_RST_OFS;
            end else if (wr_ofs[g]) begin
                ofs_q[g] <= reg_wdata;  // R15
            end
        end
    end

    // level latch on high byte read
    always_ff @(posedge clk) begin
        if (rst) begin
            lat_q <= '0;
        end else if (rd_hi) begin
            lat_q <= level;  // R4
        end
    end

    // read data select
    assign rd_mux = hit(reg_addr, `AQR_OFS_PWR2)    ? pwr2_q :
                    hit(reg_addr, `AQR_OFS_LVL_HI)  ? {3'h0, level[12:8]} :  // R3 R4
                    hit(reg_addr, `AQR_OFS_LVL_LO)  ? lat_q[7:0] :  // R5
                    hit(reg_addr, `AQR_OFS_DATA)    ? (host_pop ? q_out_data : `AQR_EMPTY_CODE) :  // R11
                    hit(reg_addr, `AQR_OFS_IDENT)   ? ID_CODE :  // R13
                    hit(reg_addr, `AQR_OFS_XOFS_HI) ? ofs_q[0] :
                    hit(reg_addr, `AQR_OFS_XOFS_LO) ? ofs_q[1] :
                    hit(reg_addr, `AQR_OFS_YOFS_HI) ? ofs_q[2] :
                    hit(reg_addr, `AQR_OFS_YOFS_LO) ? ofs_q[3] :
                    hit(reg_addr, `AQR_OFS_ZOFS_HI) ? ofs_q[4] :
                    hit(reg_addr, `AQR_OFS_ZOFS_LO) ? ofs_q[5] : 8'h00;  // R22

    // read answer one cycle after the strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
            if (reg_rd) rdata_q <= rd_mux;
        end
    end

    // overflow pulse to the status register
    always_ff @(posedge clk) begin
        if (rst) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= ovf_evt;  // R9
        end
    end

    // address pin sync and bus address
    always_ff @(posedge clk) begin
        if (rst) begin
            sel_sync_q <= 2'b00;
            addr_q     <= `AQR_I2C_ADDR_BASE;
        end else begin
            sel_sync_q <= {sel_sync_q[0], address_select_pin};
            addr_q     <= `AQR_I2C_ADDR_BASE | {6'h00, sel_sync_q[1]};  // R14
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign reg_rdata             = rdata_q;
    assign reg_rvalid            = rvalid_q;
    assign i2c_address           = addr_q;
    assign queue_low_power_allow = pwr2_q[`AQR_BIT_LP_ALLOW];
    assign x_axis_standby        = pwr2_q[`AQR_BIT_X_STBY];
    assign y_axis_standby        = pwr2_q[`AQR_BIT_Y_STBY];
    assign z_axis_standby        = pwr2_q[`AQR_BIT_Z_STBY];
    assign queue_overflow_flag   = ovf_q;
    // offset in fixed steps regardless of full scale
    assign x_offset_value        = {ofs_q[0], ofs_q[1][7:1]};  // R15 R16
    assign y_offset_value        = {ofs_q[2], ofs_q[3][7:1]};  // R15 R16
    assign z_offset_value        = {ofs_q[4], ofs_q[5][7:1]};  // R15 R16
    assign factory_x_bit         = ofs_q[1][0];  // R17
    assign factory_y_bit         = ofs_q[3][0];  // R17
    assign factory_z_bit         = ofs_q[5][0];  // R17

    // ****************************************
    // checks
    // ****************************************
    a_empty_read_ff: assert property (rd_data && !q_out_valid |=> reg_rdata == 8'hFF)  // R11
        else $error("empty data read did not return FF");
    a_level_latch: assert property (rd_hi |=> lat_q == $past(level))  // R4
        else $error("count not latched on high read");
    a_low_from_latch: assert property (rd_lo && !rd_hi |=> reg_rdata == $past(lat_q[7:0]))  // R5
        else $error("low byte not from latch");
    a_no_ff_store: assert property (q_in_valid && !host_push |-> q_in_data != 8'hFF)  // R12
        else $error("sensor FF entered queue");
    a_overflow_pulse: assert property (want && q_full && !host_pop |=> queue_overflow_flag)  // R9
        else $error("overflow not flagged");
    a_keep_mode_hold: assert property (want && q_full && queue_keep_mode && !host_pop && !queue_reset
        |=> q_cnt == $past(q_cnt) && u_fifo.rp_q == $past(u_fifo.rp_q))  // R10
        else $error("keep mode changed queue");
    a_standby_write: assert property (wr_pwr2 |=> x_axis_standby == $past(reg_wdata[5])
        && z_axis_standby == $past(reg_wdata[3]) && pwr2_q[2:0] == 3'h0)  // R2 R22
        else $error("standby bits not written");
    a_access_block: assert property (rd_data && !queue_access_en && !queue_reset && !q_in_valid
        |=> q_cnt == $past(q_cnt))  // R19
        else $error("blocked read popped queue");
    a_idle_standby: assert property (low_power_cycling && all_stby && st_q == AQR_IDLE
        |=> st_q == AQR_IDLE)  // R20
        else $error("sampled with all axes in standby");
endmodule

// File: sim/aqr_host.sv
`timescale 1ns/1ps
// ****************************************
// host processor on the register port
// ****************************************
module aqr_host (
    input  wire logic               clk,
    output logic [6:0]              reg_addr,
    output logic                    reg_wr,
    output logic                    reg_rd,
    output aqr_pkg::aqr_byte_t      reg_wdata,
    input  wire aqr_pkg::aqr_byte_t reg_rdata,
    input  wire logic               reg_rvalid
);
    import aqr_pkg::*;
    bit slow; // host idles between accesses
    initial begin
        reg_addr = 7'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // one write strobe, then lines turned over
    task automatic wr(input logic [6:0] a, input aqr_byte_t d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
        if (slow) repeat (2) @(posedge clk);
    endtask
    // one read strobe, data taken with the valid pulse
    task automatic rd(input logic [6:0] a, output aqr_byte_t d);
        d = 8'h00;
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        for (int n = 0; n < 4; n++) begin
            @(posedge clk);
            if (reg_rvalid === 1'b1) begin
                d = reg_rdata;
                break;
            end
        end
        if (slow) repeat (2) @(posedge clk);
    endtask
    // low offset byte update keeping the factory bit
    task automatic rmw_low(input logic [6:0] a, input aqr_byte_t v);
        aqr_byte_t cur;
        rd(a, cur);
        wr(a, {v[7:1], cur[0]});
    endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
    import aqr_pkg::*;
    logic         clk, rst, pin, tick, keep, acc_en, qrst, lpc;
    logic [111:0] sens;
    logic [13:0]  srcen;
    logic [6:0]   reg_addr, i2c_addr;
    logic         reg_wr, reg_rd, reg_rvalid, lp_allow, xs, ys, zs, ovf, fx, fy, fz;
    aqr_byte_t    reg_wdata, reg_rdata, hi, lo, nv;
    aqr_offset_t  xo, yo, zo;
    wire logic [15:0] ofs_f [3];
    int           num_errors, compares, ovf_n, exp_ovf, cyc;
    logic [31:0]  seed = 32'h0000_0009;
    logic [7:0]   q[$];
    assign ofs_f[0] = {fx, xo};
    assign ofs_f[1] = {fy, yo};
    assign ofs_f[2] = {fz, zo};
    aqr_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
    aqr_regs u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .address_select_pin(pin), .i2c_address(i2c_addr), .sample_tick(tick), .sensor_bytes(sens),
        .source_enable(srcen), .queue_keep_mode(keep), .queue_access_en(acc_en), .queue_reset(qrst),
        .low_power_cycling(lpc), .queue_low_power_allow(lp_allow), .x_axis_standby(xs),
        .y_axis_standby(ys), .z_axis_standby(zs), .queue_overflow_flag(ovf), .x_offset_value(xo),
        .y_offset_value(yo), .z_offset_value(zo), .factory_x_bit(fx), .factory_y_bit(fy),
        .factory_z_bit(fz));
    // ****************************************
    // clock, watchdog, overflow counter
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (rst === 1'b0 && ovf === 1'b1) ovf_n++;
        if (cyc == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    // ****************************************
    // helpers and reference model
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rc(input string nm, input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        chk(nm, {8'h00, d}, {8'h00, exp});
    endtask
    task automatic mpush(input logic [7:0] b);
        if (q.size() == 32) begin
            exp_ovf++;
            if (keep === 1'b1) return;
            void'(q.pop_front());
        end
        q.push_back(b);
    endtask
    // one tick; model appends the enabled bytes if the tick is accepted
    task automatic sample(input logic [13:0] en, input bit acc);
        logic [127:0] r;
        r = {rnd(), rnd(), rnd(), rnd()};
        r[31:24] = 8'hFF;
        @(posedge clk);
        sens  <= r[111:0];
        srcen <= en;
        tick  <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        repeat (18) @(posedge clk);
        if (acc) for (int k = 0; k < 14; k++) if (en[k]) mpush(r[8*k+:8] == 8'hFF ? 8'hFE : r[8*k+:8]);
    endtask
    // level read high then low, then pop all and one more
    task automatic drain();
        logic [12:0] lv;
        lv = 13'(q.size());
        rc("level_hi", 7'h72, {3'b000, lv[12:8]});
        rc("level_lo", 7'h73, lv[7:0]);
        while (q.size() > 0) rc("data", 7'h74, q.pop_front());
        rc("data_empty", 7'h74, 8'hFF);
    endtask
    task automatic qclear();
        @(posedge clk);
        qrst <= 1'b1;
        @(posedge clk);
        qrst <= 1'b0;
        q.delete();
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {rst, pin, tick, keep, acc_en, qrst, lpc} = 7'b1000100;
        sens = '0;
        srcen = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rc("ident", 7'h75, 8'h5A);
        rc("pwr2_rst", 7'h6C, 8'h00);
        rc("unmapped", 7'h70, 8'h00);
        u_host.wr(7'h6C, 8'hFF);
        rc("pwr2_rsv", 7'h6C, 8'hB8);
        chk("pwr_bits", {12'h000, lp_allow, xs, ys, zs}, 16'h000F);
        u_host.wr(7'h6C, 8'h28);
        @(posedge clk);
        chk("stby_bits", {12'h000, lp_allow, xs, ys, zs}, 16'h0005);
        u_host.wr(7'h75, 8'h00);
        rc("ident_ro", 7'h75, 8'h5A);
        for (int p = 1; p >= 0; p--) begin
            pin <= p[0];
            repeat (6) @(posedge clk);
            chk("i2c_addr", {9'h000, i2c_addr}, {9'h000, 6'h34, p[0]});
        end
        for (int i = 0; i < 3; i++) begin
            {hi, lo, nv} = 24'(rnd());
            u_host.wr(7'(8'h77 + 3 * i), hi);
            u_host.wr(7'(8'h78 + 3 * i), {lo[7:1], 1'b1});
            u_host.rmw_low(7'(8'h78 + 3 * i), nv);
            @(posedge clk);
            chk("offset", ofs_f[i], {1'b1, hi, nv[7:1]});
            rc("offset_hi", 7'(8'h77 + 3 * i), hi);
        end
        rc("empty", 7'h74, 8'hFF);
        u_host.wr(7'h6C, 8'h00);
        sample(14'h3FFF, 1'b1);
        drain();
        sample(14'(rnd()), 1'b1);
        u_host.slow = 1'b1;
        drain();
        u_host.slow = 1'b0;
        sample(14'h3FFF, 1'b1);
        rc("latch_hi", 7'h72, 8'h00);
        sample(14'h3FFF, 1'b1);
        rc("latch_lo", 7'h73, 8'h0E);
        drain();
        u_host.wr(7'h74, 8'hFF);
        u_host.wr(7'h74, 8'h3C);
        q.push_back(8'hFF);
        q.push_back(8'h3C);
        drain();
        for (int m = 0; m < 2; m++) begin
            keep <= m[0];
            sample(14'h3FFF, 1'b1);
            qclear();
            rc("qrst_hi", 7'h72, 8'h00);
            rc("qrst_lvl", 7'h73, 8'h00);
            {ovf_n, exp_ovf} = 64'h0;
            repeat (3) sample(14'h3FFF, 1'b1);
            chk("overflows", 16'(ovf_n), 16'(exp_ovf));
            drain();
        end
        sample(14'h3FFF, 1'b1);
        acc_en <= 1'b0;
        rc("blocked", 7'h74, 8'hFF);
        sample(14'h3FFF, 1'b0);
        acc_en <= 1'b1;
        drain();
        lpc <= 1'b1;
        sample(14'h3FFF, 1'b0);
        u_host.wr(7'h6C, 8'hB8);
        sample(14'h3FFF, 1'b0);
        u_host.wr(7'h6C, 8'h80);
        sample(14'h3FFF, 1'b1);
        drain();
        lpc <= 1'b0;
        tally_and_finish();
    end
endmodule
